// >>> src/fetm_pkg.sv
// Constants for the front-end trigger and nonlinear source mux.
// Assumes byte addressing on a 32-bit APB with word-aligned registers.
package fetm_pkg;

  localparam int          NUM_FE      = 3;
  localparam int          NUM_PWM     = 4;
  localparam int          ROUTE_W     = 14;

  // Register byte addresses, one word per front-end instance
  localparam logic [31:0] FE0_ROUTING_ADDR = 32'h0012_0000;
  localparam logic [31:0] FE1_ROUTING_ADDR = 32'h0012_0004;
  localparam logic [31:0] FE2_ROUTING_ADDR = 32'h0012_0008;

  // Field positions
  localparam int          FIRST_EDGE_LSB  = 0;
  localparam int          SECOND_EDGE_LSB = 4;
  localparam int          CYCLE_SYNC_LSB  = 8;
  localparam int          NONLINEAR_SOURCE_SELECT_LSB      = 12;
  localparam int          NONLINEAR_SOURCE_SELECT_W        = 2;

  // Nonlinear source codes
  localparam logic [1:0]  NL_FILTER0  = 2'h0;
  localparam logic [1:0]  NL_FILTER1  = 2'h1;
  localparam logic [1:0]  NL_FILTER2  = 2'h2;

  // Reset values of the three routing words
  localparam logic [13:0] FE0_ROUTING_RST = 14'h0000;
  localparam logic [13:0] FE1_ROUTING_RST = 14'h1000;
  localparam logic [13:0] FE2_ROUTING_RST = 14'h2000;

endpackage : fetm_pkg

// >>> src/fetm_route_if.sv
// Carrier between the register block and one routing lane.
// Assumes all signals live on mclk.
`timescale 1ns/1ps
interface fetm_route_if #(
  parameter int NL_W = 4
);
  logic [13:0]     routing;
  logic [3:0]      cycleSync;
  logic [3:0]      secondEdge;
  logic [3:0]      firstEdge;
  logic [NL_W-1:0] nlFilter0;
  logic [NL_W-1:0] nlFilter1;
  logic [NL_W-1:0] nlFilter2;
  logic            trigger;
  logic [NL_W-1:0] nlResult;

  modport regs (
    output routing, cycleSync, secondEdge, firstEdge, nlFilter0, nlFilter1, nlFilter2,
    input  trigger, nlResult
  );
  modport lane (
    input  routing, cycleSync, secondEdge, firstEdge, nlFilter0, nlFilter1, nlFilter2,
    output trigger, nlResult
  );
endinterface : fetm_route_if

// >>> src/fetm_route_lane.sv
// One routing lane: gates PWM triggers and picks a filter's nonlinear result.
// Assumes trigger pulses come from logic on mclk, so no synchroniser.
`timescale 1ns/1ps
module fetm_route_lane #(
  parameter int NL_W = 4
) (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   rst_n,
  // Register side and outputs
  fetm_route_if.lane  lane
);

  logic [3:0]      cycleSyncEn;
  logic [3:0]      secondEdgeEn;
  logic [3:0]      firstEdgeEn;
  logic [1:0]      nlSelect;
  logic            trigger_next;
  logic [NL_W-1:0] nlResult_next;
  logic            trigger_reg;
  logic [NL_W-1:0] nlResult_reg;

  assign cycleSyncEn  = lane.routing[fetm_pkg::CYCLE_SYNC_LSB +: 4];
  assign secondEdgeEn = lane.routing[fetm_pkg::SECOND_EDGE_LSB +: 4];
  assign firstEdgeEn  = lane.routing[fetm_pkg::FIRST_EDGE_LSB +: 4];
  assign nlSelect     = lane.routing[fetm_pkg::NONLINEAR_SOURCE_SELECT_LSB +: fetm_pkg::NONLINEAR_SOURCE_SELECT_W];

  // Any routed source fires the lane trigger
  assign trigger_next = |(lane.cycleSync & cycleSyncEn)
                      | |(lane.secondEdge & secondEdgeEn)
                      | |(lane.firstEdge & firstEdgeEn);

  always_comb begin
    case (nlSelect)
      fetm_pkg::NL_FILTER0: nlResult_next = lane.nlFilter0;
      fetm_pkg::NL_FILTER1: nlResult_next = lane.nlFilter1;
      fetm_pkg::NL_FILTER2: nlResult_next = lane.nlFilter2;
      // Reserved code drives a neutral zero rather than a stale filter
      default:              nlResult_next = '0;
    endcase
  end

  // Registered so the top outputs come from flip-flops; costs one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_reg <= 1'b0;
    end else begin
      trigger_reg <= trigger_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nlResult_reg <= '0;
    end else begin
      nlResult_reg <= nlResult_next;
    end
  end

  assign lane.trigger  = trigger_reg;
  assign lane.nlResult = nlResult_reg;

endmodule : fetm_route_lane

// >>> src/fetm_trigger_mux.sv
// Front-end trigger and nonlinear source mux: three APB routing words,
// each steering one front-end control's trigger and nonlinear input.
// Assumes PWM pulses and filter results are synchronous to mclk.
//
// Function
// - Field 13:12 picks filter 0, 1 or 2 as source of the nonlinear result.
// - The words sit at 0x00120000, 0x00120004, 0x00120008 and the first resets all zero.
// - The second word resets its nonlinear source field to 1.
// - The third word resets its nonlinear source field to 2.
// - Bits 11:8 gate cycle sync pulses of PWM 3..0 onto the lane trigger.
// - Bits 7:4 gate second-edge triggers of PWM 3..0 onto the lane trigger.
// - Bits 3:0 gate first-edge triggers of PWM 3..0 onto the lane trigger.
// - All trigger enables reset to zero and every field is read/write.
`timescale 1ns/1ps
module fetm_trigger_mux #(
  parameter int NL_W = 4
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // PWM trigger sources, bit n from channel n
  input  wire logic [3:0]             pwmCycleSync,
  input  wire logic [3:0]             pwmSecondEdge,
  input  wire logic [3:0]             pwmFirstEdge,
  // Filter nonlinear results, filter n in slice n
  input  wire logic [3*NL_W-1:0]      filterNonlinearResult,
  // Front-end control outputs, lane n in bit or slice n
  output logic      [2:0]             feTrigger,
  output logic      [3*NL_W-1:0]      feNonlinearResult
);

  if (NL_W < 1) begin : gChk
    $error("NL_W must be at least 1");
  end

  localparam int NFE  = fetm_pkg::NUM_FE;
  localparam int NPWM = fetm_pkg::NUM_PWM;
  localparam int RW   = fetm_pkg::ROUTE_W;

  // The field layout below is fixed; refuse a package that disagrees
  if (NFE != 3) begin : gChkLanes
    $error("Exactly three front-end lanes are decoded");
  end
  if (NPWM != 4) begin : gChkPwm
    $error("Each trigger group holds four PWM channels");
  end
  if (RW != 14) begin : gChkWidth
    $error("Routing word must be fourteen bits wide");
  end
  if (fetm_pkg::NONLINEAR_SOURCE_SELECT_LSB + fetm_pkg::NONLINEAR_SOURCE_SELECT_W != RW) begin : gChkTop
    $error("Source select must sit at the top of the routing word");
  end
  if (fetm_pkg::CYCLE_SYNC_LSB != fetm_pkg::SECOND_EDGE_LSB + NPWM) begin : gChkSync
    $error("Cycle sync group must follow the second-edge group");
  end
  if (fetm_pkg::SECOND_EDGE_LSB != fetm_pkg::FIRST_EDGE_LSB + NPWM) begin : gChkEdge
    $error("Second-edge group must follow the first-edge group");
  end
  if (fetm_pkg::FIRST_EDGE_LSB != 0) begin : gChkBase
    $error("First-edge group must start at bit zero");
  end

  // Reset words must match the source codes and leave every trigger blocked
  if (fetm_pkg::FE0_ROUTING_RST[13:12] != fetm_pkg::NL_FILTER0) begin : gChkRst0
    $error("First word must reset to filter 0");
  end
  if (fetm_pkg::FE1_ROUTING_RST[13:12] != fetm_pkg::NL_FILTER1) begin : gChkRst1
    $error("Second word must reset to filter 1");
  end
  if (fetm_pkg::FE2_ROUTING_RST[13:12] != fetm_pkg::NL_FILTER2) begin : gChkRst2
    $error("Third word must reset to filter 2");
  end
  if (fetm_pkg::FE0_ROUTING_RST[11:0] != 12'h000) begin : gChkEn0
    $error("First word must reset with all triggers blocked");
  end
  if (fetm_pkg::FE1_ROUTING_RST[11:0] != 12'h000) begin : gChkEn1
    $error("Second word must reset with all triggers blocked");
  end
  if (fetm_pkg::FE2_ROUTING_RST[11:0] != 12'h000) begin : gChkEn2
    $error("Third word must reset with all triggers blocked");
  end

  logic [13:0] routing_reg [NFE];
  logic [1:0]  hitIndex;
  logic        hitValid;
  logic        setupPhase;
  logic        writeStrobe;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [2:0]  laneTrigger;
  logic [3*NL_W-1:0] laneResult;

  typedef enum {
    BUS_IDLE,
    BUS_ANSWER
  } fetm_bus_state_t;

  fetm_bus_state_t busState_reg;
  fetm_bus_state_t busState_next;

  // Field view of each routing word
  logic [1:0]  nonlinearSourceSelect [NFE];
  logic [3:0]  cycleSyncRoute        [NFE];
  logic [3:0]  secondEdgeRoute       [NFE];
  logic [3:0]  firstEdgeRoute        [NFE];
  logic [13:0] readWord              [NFE];
  logic [13:0] writeMask;
  logic [13:0] writeData;
  logic [31:0] readData;

  // Address decode over the full byte address
  always_comb begin
    hitValid = 1'b1;
    hitIndex = 2'h0;
    if (paddr == fetm_pkg::FE0_ROUTING_ADDR) begin
      hitIndex = 2'h0;
    end else if (paddr == fetm_pkg::FE1_ROUTING_ADDR) begin
      hitIndex = 2'h1;
    end else if (paddr == fetm_pkg::FE2_ROUTING_ADDR) begin
      hitIndex = 2'h2;
    end else begin
      hitValid = 1'b0;
    end
  end

  assign setupPhase  = psel & ~penable;
  // Write lands at the completing edge of the access phase only
  assign writeStrobe = psel & penable & pready_reg & pwrite & hitValid;

  // Zero-wait slave: one answer cycle per setup, so back-to-back setups
  // re-enter the answer state without an idle cycle between them
  always_comb begin
    busState_next = busState_reg;
    case (busState_reg)
      BUS_IDLE: begin
        if (setupPhase) begin
          busState_next = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        if (setupPhase) begin
          busState_next = BUS_ANSWER;
        end else begin
          busState_next = BUS_IDLE;
        end
      end
      default: begin
        busState_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busState_reg <= BUS_IDLE;
    end else begin
      busState_reg <= busState_next;
    end
  end

  // Ready comes straight from a flop: high for exactly the first access cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= (busState_next == BUS_ANSWER);
    end
  end

  // Lane 0 covers bits 7:0, lane 1 bits 13:8; bits above 13 have no storage
  always_comb begin
    writeMask = 14'h0000;
    if (pstrb[0]) begin
      writeMask[7:0] = 8'hFF;
    end
    if (pstrb[1]) begin
      writeMask[13:8] = 6'h3F;
    end
  end

  assign writeData = pwdata[13:0];

  // Zero-extended read word; a miss selects word 0, zeroed by the capture below
  always_comb begin
    readData = 32'h0000_0000;
    if (hitIndex == 2'h0) begin
      readData = {18'h0_0000, readWord[0]};
    end else if (hitIndex == 2'h1) begin
      readData = {18'h0_0000, readWord[1]};
    end else if (hitIndex == 2'h2) begin
      readData = {18'h0_0000, readWord[2]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_reg <= 1'b0;
    end else if (setupPhase) begin
      pslverr_reg <= ~hitValid;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // Read data captured in setup; no write can land between setup and access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setupPhase && !pwrite && hitValid) begin
      prdata_reg <= readData;
    end else begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  for (genvar g = 0; g < NFE; g++) begin : gLane
    localparam logic [13:0] RST = (g == 0) ? fetm_pkg::FE0_ROUTING_RST :
                                  (g == 1) ? fetm_pkg::FE1_ROUTING_RST :
                                             fetm_pkg::FE2_ROUTING_RST;

    assign nonlinearSourceSelect[g] = routing_reg[g][fetm_pkg::NONLINEAR_SOURCE_SELECT_LSB +: fetm_pkg::NONLINEAR_SOURCE_SELECT_W];
    assign cycleSyncRoute[g]        = routing_reg[g][fetm_pkg::CYCLE_SYNC_LSB +: 4];
    assign secondEdgeRoute[g]       = routing_reg[g][fetm_pkg::SECOND_EDGE_LSB +: 4];
    assign firstEdgeRoute[g]        = routing_reg[g][fetm_pkg::FIRST_EDGE_LSB +: 4];
    assign readWord[g]              = {nonlinearSourceSelect[g], cycleSyncRoute[g],
                                       secondEdgeRoute[g], firstEdgeRoute[g]};

    // Bits 13:8 in lane 1, 7:0 in lane 0; upper lanes carry nothing
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        routing_reg[g] <= RST;
      end else if (writeStrobe && hitIndex == 2'(g)) begin
        // Unstrobed bytes keep their stored value
        routing_reg[g] <= (routing_reg[g] & ~writeMask) | (writeData & writeMask);
      end
    end

    fetm_route_if #(.NL_W(NL_W)) link ();

    assign link.routing    = routing_reg[g];
    assign link.cycleSync  = pwmCycleSync;
    assign link.secondEdge = pwmSecondEdge;
    assign link.firstEdge  = pwmFirstEdge;
    assign link.nlFilter0  = filterNonlinearResult[0*NL_W +: NL_W];
    assign link.nlFilter1  = filterNonlinearResult[1*NL_W +: NL_W];
    assign link.nlFilter2  = filterNonlinearResult[2*NL_W +: NL_W];

    fetm_route_lane #(.NL_W(NL_W)) uLane (
      .mclk (mclk),
      .rst_n(rst_n),
      .lane (link.lane)
    );

    assign laneTrigger[g]           = link.trigger;
    assign laneResult[g*NL_W +: NL_W] = link.nlResult;
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign feTrigger         = laneTrigger;
  assign feNonlinearResult = laneResult;

endmodule : fetm_trigger_mux

// >>> dv/fetm_source_model.sv
// PWM channels and loop filters feeding the mux.
// Assumes bench requests on mclk; a request shows at the outputs one cycle later.
`timescale 1ns/1ps
module fetm_source_model #(parameter int NL_W = 4) (
  // Clock and reset
  input wire logic mclk, rst_n,
  // Bench requests
  input wire logic [11:0] pulseReq,
  input wire logic [3*NL_W-1:0] resultReq,
  // Sources toward the mux
  output logic [3:0] cycleSync, secondEdge, firstEdge,
  output logic [3*NL_W-1:0] nlResult
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {cycleSync, secondEdge, firstEdge} <= 12'h000;
      nlResult <= '0;
    end else begin
      {cycleSync, secondEdge, firstEdge} <= pulseReq;
      nlResult <= resultReq;
    end
  end
endmodule : fetm_source_model

// >>> dv/fetm_trigger_mux_monitor.sv
// Checker on the mux top ports, shadowing the routing words.
// Assumes zero-wait APB and one-cycle registered outputs.
`timescale 1ns/1ps
module fetm_trigger_mux_monitor #(parameter int NL_W = 4) (
  // Clock, reset, APB
  input wire logic mclk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [31:0] paddr, pwdata, prdata,
  input wire logic [3:0] pstrb, pwmCycleSync, pwmSecondEdge, pwmFirstEdge,
  // Filters and lanes
  input wire logic [3*NL_W-1:0] filterNonlinearResult, feNonlinearResult,
  input wire logic [2:0] feTrigger
);
  logic [13:0] wordReg[3];
  logic [2:0] trigNow, trigPrev;
  logic [3*NL_W-1:0] nlNow, nlPrev;
  logic armed, hit;
  assign hit = paddr inside {fetm_pkg::FE0_ROUTING_ADDR, fetm_pkg::FE1_ROUTING_ADDR,
    fetm_pkg::FE2_ROUTING_ADDR};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wordReg <= '{fetm_pkg::FE0_ROUTING_RST, fetm_pkg::FE1_ROUTING_RST,
        fetm_pkg::FE2_ROUTING_RST};
    end else if (psel && penable && pready && pwrite && hit) begin
      if (pstrb[0]) wordReg[paddr[3:2]][7:0] <= pwdata[7:0];
      if (pstrb[1]) wordReg[paddr[3:2]][13:8] <= pwdata[13:8];
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      trigNow[i] = |({pwmCycleSync, pwmSecondEdge, pwmFirstEdge} & wordReg[i][11:0]);
      nlNow[i*NL_W +: NL_W] = (wordReg[i][13:12] == 2'h3) ? '0 :
        filterNonlinearResult[wordReg[i][13:12]*NL_W +: NL_W];
    end
  end
  // Expected lane outputs one cycle on; armed skips the edge right after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {armed, trigPrev, nlPrev} <= '0;
    end else begin
      {armed, trigPrev, nlPrev} <= {1'b1, trigNow, nlNow};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready stuck");
  a_err_unmapped: assert property (s_setup ##1 s_access |-> pslverr == !hit)
    else $error("pslverr wrong");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
  a_top_bits_zero: assert property (pready |-> prdata[31:14] == 18'h0)
    else $error("upper bits set");
  a_read_back: assert property (s_access ##0 (!pwrite && hit)
    |-> prdata == {18'h0, wordReg[paddr[3:2]]})
    else $error("read data wrong");
  a_trig_route: assert property (armed |-> feTrigger == trigPrev)
    else $error("trigger wrong");
  a_nl_select: assert property (armed |-> feNonlinearResult == nlPrev)
    else $error("nonlinear wrong");
endmodule : fetm_trigger_mux_monitor

// >>> dv/fetm_trigger_mux_tb.sv
// Bench for the trigger mux: APB master, directed and seeded random traffic.
// Assumes the source model and monitor beside it.
`timescale 1ns/1ps
module fetm_trigger_mux_tb;
  localparam int NL_W = 4;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd, v;
  logic [31:0] w[3];
  logic [3:0] pstrb, cs, se, fe;
  logic [11:0] req, s;
  logic [3*NL_W-1:0] fres, freq, fnl;
  logic [2:0] ftr;
  logic [31:0] ad[3] = '{fetm_pkg::FE0_ROUTING_ADDR, fetm_pkg::FE1_ROUTING_ADDR,
    fetm_pkg::FE2_ROUTING_ADDR};
  logic [13:0] rv[3] = '{fetm_pkg::FE0_ROUTING_RST, fetm_pkg::FE1_ROUTING_RST,
    fetm_pkg::FE2_ROUTING_RST};
  int fails, n_tests;

  fetm_trigger_mux #(.NL_W(NL_W)) DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwmCycleSync(cs),
    .pwmSecondEdge(se), .pwmFirstEdge(fe), .filterNonlinearResult(fres),
    .feTrigger(ftr), .feNonlinearResult(fnl));
  fetm_source_model #(.NL_W(NL_W)) u_src (.mclk(mclk), .rst_n(rst_n), .pulseReq(req),
    .resultReq(freq), .cycleSync(cs), .secondEdge(se), .firstEdge(fe), .nlResult(fres));

  function automatic logic trig_exp(input logic [31:0] x, input logic [11:0] p);
    return |(x[11:0] & p);
  endfunction : trig_exp
  function automatic logic [31:0] nl_exp(input logic [1:0] sel, input logic [11:0] f);
    return (sel == 2'h3) ? 32'h0 : 32'(f[sel*NL_W +: NL_W]);
  endfunction : nl_exp

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) fails++;
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  // Source pulse lands one edge later, output one edge after that
  task automatic pulse(input logic [11:0] p);
    @(posedge mclk);
    req <= p;
    @(posedge mclk);
    req <= 12'h000;
    @(posedge mclk);
    #1;
  endtask : pulse
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    finish_test();
  end
  initial begin
    v = $urandom(32'hCE6D);
    {rst_n, psel, penable, pwrite, paddr, pwdata, req, freq, fails, n_tests} = '0;
    pstrb = 4'hF;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk("reset", rd, {18'h0, rv[i]});
    end
    apb(1'b1, 32'h0012_000C, 32'hFFFF_FFFF);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 4; k++) begin
        v = $urandom;
        v[13:12] = k[1:0];
        freq <= v[31:20];
        apb(1'b1, ad[i], v);
        apb(1'b0, ad[i], 32'h0);
        chk("readback", rd, {18'h0, v[13:0]});
        chk("nonlinear", 32'(fnl[i*NL_W +: NL_W]), nl_exp(k[1:0], freq));
      end
      apb(1'b1, ad[i], 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      for (int b = 0; b < 12; b++) begin
        apb(1'b1, ad[i], 32'h1 << b);
        pulse(12'h1 << b);
        chk("routed", 32'(ftr), 32'h1 << i);
        pulse(~(12'h1 << b));
        chk("blocked", 32'(ftr), 32'h0);
        apb(1'b1, ad[i], 32'h0);
      end
    end
    repeat (20) begin
      for (int i = 0; i < 3; i++) begin
        w[i] = $urandom;
        apb(1'b1, ad[i], w[i]);
      end
      v = $urandom;
      s = v[11:0];
      pulse(s);
      chk("merged", 32'(ftr), 32'({trig_exp(w[2], s), trig_exp(w[1], s), trig_exp(w[0], s)}));
    end
    finish_test();
  end
endmodule : fetm_trigger_mux_tb

bind fetm_trigger_mux fetm_trigger_mux_monitor #(.NL_W(NL_W)) u_mon (.mclk(mclk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
  .pwmCycleSync(pwmCycleSync), .pwmSecondEdge(pwmSecondEdge), .pwmFirstEdge(pwmFirstEdge),
  .filterNonlinearResult(filterNonlinearResult), .feNonlinearResult(feNonlinearResult),
  .feTrigger(feTrigger));
